// ### sdf_pkg.sv
// Shared constants and types for the serial port with DTR/DSR flow control
`default_nettype none
package sdf_pkg;
    localparam int unsigned CLK_HZ       = 25000000;
    localparam int unsigned OVS          = 16;
    localparam logic [2:0]  BAUD_300     = 3'h0;
    localparam logic [2:0]  BAUD_600     = 3'h1;
    localparam logic [2:0]  BAUD_1200    = 3'h2;
    localparam logic [2:0]  BAUD_2400    = 3'h3;
    localparam logic [2:0]  BAUD_4800    = 3'h4;
    localparam logic [2:0]  BAUD_9600    = 3'h5;
    localparam logic [2:0]  BAUD_DEFAULT = BAUD_9600;
    localparam logic [1:0]  PAR_NONE     = 2'h0;
    localparam logic [1:0]  PAR_EVEN     = 2'h1;
    localparam logic [1:0]  PAR_ODD      = 2'h2;
    localparam int unsigned STOP_BITS    = 2;
    localparam logic [7:0]  CTRL_C       = 8'h03;
    localparam logic [7:0]  NEWLINE      = 8'h0A;
    localparam int unsigned RX_DEPTH     = 128;
    localparam int unsigned RX_FULL_LVL  = 100;
    localparam int unsigned TX_DEPTH     = 8;
    localparam int unsigned DW           = 8;

    typedef enum logic [2:0] {
        SDF_IDLE  = 3'b000,
        SDF_START = 3'b001,
        SDF_DATA  = 3'b010,
        SDF_PAR   = 3'b011,
        SDF_STOP  = 3'b100
    } sdf_bit_t;
endpackage
`default_nettype wire

// ### sdf_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sdf_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rd_ff];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge mclk)
    begin
        if (push)
            mem_ff[wr_ff] <= in_data;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end
        else if (flush)
        begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            if (pop)
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ### sdf_uart.sv
// Serial port with DTR/DSR hold-off, receive buffer and Ctrl-C abort
// Notes on behaviour
// - A frame runs from start bit to last stop bit; rate, width, parity selectable.
// - Always one start bit and two stop bits.
// - Characters are accepted whatever DTR shows, while the receive buffer has room.
// - DTR false when about 100 characters buffered; true again once consumed.
// - After a query and newline, DTR goes false to send the response.
// - After the response is sent, DTR returns true unless 100 or more characters are buffered.
// - DSR is sampled before each character; output waits while DSR is false.
// - DTR stays false all the while output is held by DSR.
// - Ctrl-C aborts the operation and discards all pending output.
// - Rates 300 to 9600 baud, 9600 by default.
// - No parity means eight data bits; even or odd means seven.
`timescale 1ns/1ps
`default_nettype none
module sdf_uart (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic [2:0] baud_sel,
    input  wire logic [1:0] parity_sel,
    input  wire logic       rxd,
    output logic            txd,
    output logic            dtr,
    input  wire logic       dsr,
    output logic [7:0]      rd_data,
    output logic            rd_valid,
    input  wire logic       rd_ack,
    input  wire logic       query_done,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_valid,
    output logic            wr_ready,
    input  wire logic       resp_last,
    output logic            clear_pulse,
    output logic            parity_err,
    output logic            overrun
);
    localparam int unsigned RAW = $clog2(sdf_pkg::RX_DEPTH);

    function automatic logic [15:0] tick_div(input logic [2:0] sel);
        logic [15:0] d;
        d = 16'(sdf_pkg::CLK_HZ / (sdf_pkg::OVS * 9600));
        case (sel)
            sdf_pkg::BAUD_300:  tick_div = 16'(sdf_pkg::CLK_HZ / (sdf_pkg::OVS * 300));
            sdf_pkg::BAUD_600:  tick_div = 16'(sdf_pkg::CLK_HZ / (sdf_pkg::OVS * 600));
            sdf_pkg::BAUD_1200: tick_div = 16'(sdf_pkg::CLK_HZ / (sdf_pkg::OVS * 1200));
            sdf_pkg::BAUD_2400: tick_div = 16'(sdf_pkg::CLK_HZ / (sdf_pkg::OVS * 2400));
            sdf_pkg::BAUD_4800: tick_div = 16'(sdf_pkg::CLK_HZ / (sdf_pkg::OVS * 4800));
            default:            tick_div = d;
        endcase
    endfunction

    function automatic logic [3:0] data_bits(input logic [1:0] par);
        data_bits = (par == sdf_pkg::PAR_NONE) ? 4'h8 : 4'h7;
    endfunction

    function automatic logic par_bit(input logic [7:0] d, input logic [1:0] par);
        par_bit = (^d[6:0]) ^ (par == sdf_pkg::PAR_ODD);
    endfunction

    // Pin synchronisers
    logic rx_s1_ff, rx_s2_ff, dsr_s1_ff, dsr_s2_ff;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_s1_ff  <= 1'b1;
            rx_s2_ff  <= 1'b1;
            dsr_s1_ff <= 1'b0;
            dsr_s2_ff <= 1'b0;
        end
        else
        begin
            rx_s1_ff  <= rxd;
            rx_s2_ff  <= rx_s1_ff;
            dsr_s1_ff <= dsr;
            dsr_s2_ff <= dsr_s1_ff;
        end
    end

    // Oversample tick from the selected rate
    logic [15:0] div_ff;
    logic        tick_ff;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end
        else if (div_ff >= tick_div(baud_sel) - 16'h0001)
        begin
            div_ff  <= '0;
            tick_ff <= 1'b1;
        end
        else
        begin
            div_ff  <= div_ff + 16'h0001;
            tick_ff <= 1'b0;
        end
    end

    // Receiver
    sdf_pkg::sdf_bit_t rx_st_ff;
    logic [3:0] rx_os_ff, rx_bit_ff;
    logic [7:0] rx_sh_ff;
    logic       rx_done_ff;
    logic       dtr_ff;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_st_ff   <= sdf_pkg::SDF_IDLE;
            rx_os_ff   <= '0;
            rx_bit_ff  <= '0;
            rx_sh_ff   <= '0;
            rx_done_ff <= 1'b0;
            parity_err <= 1'b0;
        end
        else
        begin
            rx_done_ff <= 1'b0;
            if (tick_ff)
            begin
                rx_os_ff <= rx_os_ff + 4'h1;
                case (rx_st_ff)
                    sdf_pkg::SDF_IDLE:
                        if (!rx_s2_ff)
                        begin
                            rx_st_ff <= sdf_pkg::SDF_START;
                            rx_os_ff <= '0;
                        end
                    sdf_pkg::SDF_START:
                        if (rx_os_ff == 4'(sdf_pkg::OVS/2 - 1))
                        begin
                            rx_os_ff  <= '0;
                            rx_bit_ff <= '0;
                            rx_sh_ff  <= '0;
                            rx_st_ff  <= rx_s2_ff ? sdf_pkg::SDF_IDLE : sdf_pkg::SDF_DATA;
                        end
                    sdf_pkg::SDF_DATA:
                        if (rx_os_ff == 4'(sdf_pkg::OVS - 1))
                        begin
                            rx_sh_ff[rx_bit_ff[2:0]] <= rx_s2_ff;
                            rx_bit_ff <= rx_bit_ff + 4'h1;
                            if (rx_bit_ff == data_bits(parity_sel) - 4'h1)
                                rx_st_ff <= (parity_sel == sdf_pkg::PAR_NONE) ?
                                            sdf_pkg::SDF_STOP : sdf_pkg::SDF_PAR;
                        end
                    sdf_pkg::SDF_PAR:
                        if (rx_os_ff == 4'(sdf_pkg::OVS - 1))
                        begin
                            parity_err <= rx_s2_ff != par_bit(rx_sh_ff, parity_sel);
                            rx_st_ff   <= sdf_pkg::SDF_STOP;
                        end
                    sdf_pkg::SDF_STOP:
                        // Deliver at the first stop bit's middle; the second one is idle time
                        if (rx_os_ff == 4'(sdf_pkg::OVS - 1))
                        begin
                            rx_done_ff <= 1'b1;
                            rx_st_ff   <= sdf_pkg::SDF_IDLE;
                        end
                    default: rx_st_ff <= sdf_pkg::SDF_IDLE;
                endcase
            end
        end
    end

    // Receive buffer
    logic [7:0]   rxb_mem [sdf_pkg::RX_DEPTH];
    logic [RAW-1:0] rxb_wr_ff, rxb_rd_ff;
    logic [RAW:0]   rxb_cnt_ff;
    logic           is_ctrl_c, rx_push, rx_pop, abort;
    assign is_ctrl_c = rx_done_ff && (rx_sh_ff == sdf_pkg::CTRL_C);
    assign abort     = is_ctrl_c;
    // Chars arriving during hold-off are still kept while room remains (28-char slack)
    assign rx_push   = rx_done_ff && !is_ctrl_c && (rxb_cnt_ff != (RAW+1)'(sdf_pkg::RX_DEPTH));
    assign rx_pop    = rd_valid && rd_ack;

    always_ff @(posedge mclk)
    begin
        if (rx_push)
            rxb_mem[rxb_wr_ff] <= rx_sh_ff;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxb_wr_ff  <= '0;
            rxb_rd_ff  <= '0;
            rxb_cnt_ff <= '0;
            rd_valid   <= 1'b0;
            rd_data    <= '0;
            overrun    <= 1'b0;
        end
        else if (abort)
        begin
            rxb_wr_ff  <= '0;
            rxb_rd_ff  <= '0;
            rxb_cnt_ff <= '0;
            rd_valid   <= 1'b0;
        end
        else
        begin
            overrun <= rx_done_ff && !rx_push;
            if (rx_push)
                rxb_wr_ff <= rxb_wr_ff + 1'b1;
            if (!rd_valid || rx_pop)
            begin
                rd_valid <= (rxb_cnt_ff != '0);
                rd_data  <= rxb_mem[rxb_rd_ff];
                if (rxb_cnt_ff != '0)
                    rxb_rd_ff <= rxb_rd_ff + 1'b1;
            end
            rxb_cnt_ff <= rxb_cnt_ff + (RAW+1)'(rx_push)
                          - (RAW+1)'((!rd_valid || rx_pop) && (rxb_cnt_ff != '0));
        end
    end

    // Response path: FIFO then transmitter
    logic [sdf_pkg::DW:0] tf_data;
    logic       tf_valid, tf_ready, talk_ff;
    // The last-byte mark travels with its own byte, so a multi-byte reply ends on the right one
    sdf_fifo #(.WIDTH(sdf_pkg::DW + 1), .DEPTH(sdf_pkg::TX_DEPTH)) u_txq (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .flush     (abort),
        .in_data   ({resp_last, wr_data}),
        .in_valid  (wr_valid && talk_ff),
        .in_ready  (wr_ready),
        .out_data  (tf_data),
        .out_valid (tf_valid),
        .out_ready (tf_ready)
    );

    sdf_pkg::sdf_bit_t tx_st_ff;
    logic [3:0] tx_os_ff, tx_bit_ff;
    logic [7:0] tx_sh_ff;
    logic       tx_last_ff, resp_end_ff;
    assign tf_ready = (tx_st_ff == sdf_pkg::SDF_IDLE) && dsr_s2_ff && tick_ff;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_st_ff    <= sdf_pkg::SDF_IDLE;
            tx_os_ff    <= '0;
            tx_bit_ff   <= '0;
            tx_sh_ff    <= '0;
            tx_last_ff  <= 1'b0;
            resp_end_ff <= 1'b0;
            txd         <= 1'b1;
        end
        else if (abort)
        begin
            tx_st_ff    <= sdf_pkg::SDF_IDLE;
            txd         <= 1'b1;
            resp_end_ff <= 1'b0;
        end
        else
        begin
            resp_end_ff <= 1'b0;
            if (tick_ff)
            begin
                tx_os_ff <= tx_os_ff + 4'h1;
                case (tx_st_ff)
                    sdf_pkg::SDF_IDLE:
                        if (tf_valid && dsr_s2_ff)
                        begin
                            tx_sh_ff   <= tf_data[sdf_pkg::DW-1:0];
                            tx_last_ff <= tf_data[sdf_pkg::DW];
                            tx_os_ff   <= '0;
                            txd        <= 1'b0;
                            tx_st_ff   <= sdf_pkg::SDF_START;
                        end
                    sdf_pkg::SDF_START:
                        if (tx_os_ff == 4'(sdf_pkg::OVS - 1))
                        begin
                            txd       <= tx_sh_ff[0];
                            tx_bit_ff <= 4'h1;
                            tx_st_ff  <= sdf_pkg::SDF_DATA;
                        end
                    sdf_pkg::SDF_DATA:
                        if (tx_os_ff == 4'(sdf_pkg::OVS - 1))
                        begin
                            tx_bit_ff <= tx_bit_ff + 4'h1;
                            if (tx_bit_ff == data_bits(parity_sel))
                            begin
                                txd      <= (parity_sel == sdf_pkg::PAR_NONE) ?
                                            1'b1 : par_bit(tx_sh_ff, parity_sel);
                                tx_bit_ff <= '0;
                                tx_st_ff <= (parity_sel == sdf_pkg::PAR_NONE) ?
                                            sdf_pkg::SDF_STOP : sdf_pkg::SDF_PAR;
                            end
                            else
                                txd <= tx_sh_ff[tx_bit_ff[2:0]];
                        end
                    sdf_pkg::SDF_PAR:
                        if (tx_os_ff == 4'(sdf_pkg::OVS - 1))
                        begin
                            txd       <= 1'b1;
                            tx_bit_ff <= '0;
                            tx_st_ff  <= sdf_pkg::SDF_STOP;
                        end
                    sdf_pkg::SDF_STOP:
                        if (tx_os_ff == 4'(sdf_pkg::OVS - 1))
                        begin
                            tx_bit_ff <= tx_bit_ff + 4'h1;
                            if (tx_bit_ff == 4'(sdf_pkg::STOP_BITS - 1))
                            begin
                                tx_st_ff    <= sdf_pkg::SDF_IDLE;
                                resp_end_ff <= tx_last_ff;
                            end
                        end
                    default: tx_st_ff <= sdf_pkg::SDF_IDLE;
                endcase
            end
        end
    end

    // Talk phase runs from query plus newline to the end of the last response byte
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            talk_ff <= 1'b0;
        else if (abort)
            talk_ff <= 1'b0;
        else if (query_done)
            talk_ff <= 1'b1;
        else if (resp_end_ff)
            talk_ff <= 1'b0;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            dtr_ff <= 1'b0;
        else
            dtr_ff <= (rxb_cnt_ff < (RAW+1)'(sdf_pkg::RX_FULL_LVL))
                      && !talk_ff && !query_done;
    end
    assign dtr = dtr_ff;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            clear_pulse <= 1'b0;
        else
            clear_pulse <= abort;
    end
endmodule
`default_nettype wire

// ### sdf_uart_sva.sv
// Port-level assertions for the serial port with DTR/DSR flow control
`timescale 1ns/1ps
`default_nettype none
module sdf_uart_sva (
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire logic [2:0] baud_sel,
    input wire logic [1:0] parity_sel,
    input wire logic       rxd,
    input wire logic       txd,
    input wire logic       dtr,
    input wire logic       dsr,
    input wire logic [7:0] rd_data,
    input wire logic       rd_valid,
    input wire logic       rd_ack,
    input wire logic       query_done,
    input wire logic [7:0] wr_data,
    input wire logic       wr_valid,
    input wire logic       wr_ready,
    input wire logic       resp_last,
    input wire logic       clear_pulse,
    input wire logic       parity_err,
    input wire logic       overrun
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_dtr_after_reset: assert property ($rose(rst_b) |=> dtr)
        else $error("dtr not raised after reset");
    a_talk_holds_dtr: assert property (query_done |=> !dtr [*8])
        else $error("dtr not held low after query");
    a_tx_in_talk: assert property ($fell(txd) |-> !dtr)
        else $error("transmit while dtr high");
    a_clear_one_cycle: assert property (clear_pulse |=> !clear_pulse)
        else $error("clear pulse too long");
    a_abort_frees_dtr: assert property (clear_pulse |-> ##[0:4] dtr)
        else $error("dtr not restored after abort");
    a_overrun_single: assert property (overrun |=> !overrun)
        else $error("overrun pulse too long");
    // A Ctrl-C flush may legally drop a byte that is still waiting
    a_rd_held: assert property (rd_valid && !rd_ack |=> (rd_valid && $stable(rd_data)) || clear_pulse)
        else $error("received byte not held");
    a_no_parity_err: assert property (parity_sel == sdf_pkg::PAR_NONE && $stable(parity_sel)
        |=> $stable(parity_err))
        else $error("parity error without parity");

    c_rx_byte: cover property (rd_valid && rd_ack);
    c_abort: cover property (clear_pulse);
    c_talk: cover property (query_done ##1 !dtr);
endmodule

bind sdf_uart sdf_uart_sva i_sdf_uart_sva (
    .mclk(mclk), .rst_b(rst_b), .baud_sel(baud_sel), .parity_sel(parity_sel),
    .rxd(rxd), .txd(txd), .dtr(dtr), .dsr(dsr), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ack(rd_ack), .query_done(query_done), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .resp_last(resp_last), .clear_pulse(clear_pulse),
    .parity_err(parity_err), .overrun(overrun)
);
`default_nettype wire

// ### sdf_host.sv
// Behavioural host terminal: serial sender, serial receiver and DSR driver
`timescale 1ns/1ps
`default_nettype none
module sdf_host #(
    parameter int BIT_CYC = 2592
) (
    input  wire logic      mclk,
    output var logic       rxd,
    input  wire logic      txd,
    input  wire logic      dtr,
    input  wire logic      ready,
    output logic           dsr,
    output var logic [7:0] got_byte,
    output var logic       got_valid
);
    logic [7:0] sh;

    // DSR follows the bench so that suspension and deadlock can be staged
    assign dsr = ready;
    initial rxd = 1'b1;

    // Honours hold-off unless told to push a character through regardless
    task automatic send(input logic [7:0] v, input logic force_it);
        int n;
        n = 0;
        while (dtr !== 1'b1 && force_it !== 1'b1 && n < 400000)
        begin
            @(posedge mclk);
            n++;
        end
        @(posedge mclk);
        rxd <= 1'b0;
        repeat (BIT_CYC) @(posedge mclk);
        for (int i = 0; i < 8; i++)
        begin
            rxd <= v[i];
            repeat (BIT_CYC) @(posedge mclk);
        end
        rxd <= 1'b1;
        repeat (2 * BIT_CYC) @(posedge mclk);
    endtask

    // Mid-bit sampling; a framing fault leaves the byte unreported
    initial
    begin
        got_valid = 1'b0;
        got_byte = 8'h00;
        forever
        begin
            @(negedge txd);
            repeat (BIT_CYC / 2) @(posedge mclk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CYC) @(posedge mclk);
                sh[i] = txd;
            end
            repeat (BIT_CYC) @(posedge mclk);
            got_byte <= sh;
            got_valid <= txd;
            @(posedge mclk);
            got_valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the serial port with DTR/DSR flow control
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int BIT = 2592;
    logic       mclk;
    logic       rst_b;
    logic [2:0] baud_sel;
    logic [1:0] parity_sel;
    logic       rxd;
    logic       txd;
    logic       dtr;
    logic       dsr;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       rd_ack;
    logic       query_done;
    logic [7:0] wr_data;
    logic       wr_valid;
    logic       wr_ready;
    logic       resp_last;
    logic       clear_pulse;
    logic       parity_err;
    logic       overrun;
    logic       ready;
    logic [7:0] got_byte;
    logic       got_valid;
    logic [7:0] b;
    logic [7:0] exp_rx[$];
    logic [7:0] exp_tx[$];
    int         fail_count;
    int         n_checks;
    int         low_cnt;

    sdf_uart i_sdf_uart (
        .mclk(mclk), .rst_b(rst_b), .baud_sel(baud_sel), .parity_sel(parity_sel),
        .rxd(rxd), .txd(txd), .dtr(dtr), .dsr(dsr), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_ack(rd_ack), .query_done(query_done), .wr_data(wr_data), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .resp_last(resp_last), .clear_pulse(clear_pulse),
        .parity_err(parity_err), .overrun(overrun)
    );
    sdf_host #(.BIT_CYC(BIT)) i_sdf_host (
        .mclk(mclk), .rxd(rxd), .txd(txd), .dtr(dtr), .ready(ready), .dsr(dsr),
        .got_byte(got_byte), .got_valid(got_valid)
    );

    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic pulse_query;
        @(posedge mclk);
        query_done <= 1'b1;
        @(posedge mclk);
        query_done <= 1'b0;
    endtask

    task automatic put_resp(input logic [7:0] v);
        int n;
        n = 0;
        @(posedge mclk);
        wr_data <= v;
        wr_valid <= 1'b1;
        resp_last <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (wr_ready !== 1'b1 && n < 100);
        if (wr_ready !== 1'b1)
            fail_count++;
        wr_valid <= 1'b0;
        resp_last <= 1'b0;
    endtask

    // A result with no note waiting is a mismatch in itself
    always @(posedge mclk)
    begin
        rd_ack <= 1'b0;
        if (rd_valid === 1'b1 && rd_ack !== 1'b1)
        begin
            rd_ack <= 1'b1;
            if (exp_rx.size() == 0)
                cmp1(rd_valid, 1'b0);
            else
                cmp8(rd_data, exp_rx.pop_front());
        end
        if (got_valid === 1'b1 && exp_tx.size() == 0)
            cmp1(got_valid, 1'b0);
        else if (got_valid === 1'b1)
            cmp8(got_byte, exp_tx.pop_front());
        if (overrun === 1'b1)
            cmp1(overrun, 1'b0);
    end

    // Three frames of eleven bit times plus short windows; stays under 100k cycles
    initial
    begin
        #3900000;
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        rst_b = 1'b0;
        baud_sel = sdf_pkg::BAUD_9600;
        parity_sel = sdf_pkg::PAR_EVEN;
        query_done = 1'b0;
        wr_data = 8'h00;
        wr_valid = 1'b0;
        resp_last = 1'b0;
        ready = 1'b1;
        fail_count = 0;
        n_checks = 0;
        void'($urandom(82));
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        b = 8'($urandom_range(32'h7E, 32'h20));
        // Eight host bits carry seven data bits and the even parity bit
        b[7] = ^b[6:0];
        exp_rx.push_back({1'b0, b[6:0]});
        i_sdf_host.send(b, 1'b0);
        repeat (200) @(negedge mclk);
        cmp8(8'(exp_rx.size()), 8'h00);
        cmp1(parity_err, 1'b0);
        @(posedge mclk);
        ready <= 1'b0;
        parity_sel <= sdf_pkg::PAR_ODD;
        pulse_query();
        @(negedge mclk);
        cmp1(dtr, 1'b0);
        b = 8'($urandom_range(32'h7E, 32'h20));
        exp_tx.push_back({~^b[6:0], b[6:0]});
        put_resp(b);
        low_cnt = 0;
        repeat (BIT) @(negedge mclk) low_cnt += int'(txd !== 1'b1);
        cmp1(low_cnt != 0, 1'b0);
        cmp1(dtr, 1'b0);
        @(posedge mclk);
        ready <= 1'b1;
        repeat (13 * BIT)
        begin
            @(negedge mclk);
            if (exp_tx.size() == 0 && dtr === 1'b1)
                break;
        end
        cmp8(8'(exp_tx.size()), 8'h00);
        cmp1(dtr, 1'b1);
        @(posedge mclk);
        ready <= 1'b0;
        parity_sel <= sdf_pkg::PAR_NONE;
        pulse_query();
        put_resp(8'hC0 | b);
        fork
            i_sdf_host.send(sdf_pkg::CTRL_C, 1'b1);
        join_none
        repeat (12 * BIT)
        begin
            @(negedge mclk);
            if (clear_pulse === 1'b1)
                break;
        end
        cmp1(clear_pulse, 1'b1);
        @(posedge mclk);
        ready <= 1'b1;
        low_cnt = 0;
        repeat (BIT) @(negedge mclk) low_cnt += int'(txd !== 1'b1);
        cmp1(low_cnt != 0, 1'b0);
        cmp1(dtr, 1'b1);
        cmp1(rd_valid, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
